// [src/pct_pkg.sv]
package pct_pkg;

	// Instruction classes as seen by the decode stage
	typedef enum logic [3:0] {
		PCT_ALU      = 4'h0,
		PCT_CSR      = 4'h1,
		PCT_LOAD     = 4'h2,
		PCT_STORE    = 4'h3,
		PCT_ELW      = 4'h4,
		PCT_MUL      = 4'h5,
		PCT_MULH     = 4'h6,
		PCT_DIV      = 4'h7,
		PCT_JUMP     = 4'h8,
		PCT_JUMP_REG = 4'h9,
		PCT_BRANCH   = 4'ha,
		PCT_FENCE    = 4'hb
	} pct_cls_t;

	localparam int CNT_W = 6;

	// Cycle figures per class, zero wait states on both memory sides
	localparam logic [CNT_W-1:0] CYC_ALU       = 6'h01;
	localparam logic [CNT_W-1:0] CYC_CSR_SLOW  = 6'h04;
	localparam logic [CNT_W-1:0] CYC_CSR_FAST  = 6'h01;
	localparam logic [CNT_W-1:0] CYC_MEM       = 6'h01;
	localparam logic [CNT_W-1:0] CYC_MEM_SPLIT = 6'h02;
	localparam logic [CNT_W-1:0] CYC_ELW       = 6'h04;
	localparam logic [CNT_W-1:0] CYC_MUL       = 6'h01;
	localparam logic [CNT_W-1:0] CYC_MULH      = 6'h05;
	localparam logic [CNT_W-1:0] CYC_DIV_MIN   = 6'h03;
	localparam logic [CNT_W-1:0] CYC_DIV_MAX   = 6'h23;
	localparam logic [CNT_W-1:0] CYC_JUMP      = 6'h02;
	localparam logic [CNT_W-1:0] CYC_JUMP_ODD  = 6'h03;
	localparam logic [CNT_W-1:0] CYC_BR_TAKEN  = 6'h03;
	localparam logic [CNT_W-1:0] CYC_BR_ODD    = 6'h04;
	localparam logic [CNT_W-1:0] CYC_FENCE     = 6'h02;
	localparam logic [CNT_W-1:0] CYC_FENCE_ODD = 6'h03;
	localparam logic [CNT_W-1:0] CYC_ONE       = 6'h01;
	localparam logic [1:0]       WB_ONE        = 2'h1;
	localparam logic [1:0]       WB_SPLIT      = 2'h2;
	localparam logic [31:0]      FENCE_STEP    = 32'h0000_0004;
	localparam logic [4:0]       REG_ZERO      = 5'h00;

	// Decoded instruction handed from fetch to decode
	typedef struct packed {
		pct_cls_t    cls;
		logic [31:0] pc;
		logic [31:0] target;    // Jump target
		logic        tgt_odd;   // Target is uncompressed and not word aligned
		logic        csr_slow;  // CSR belongs to the four-cycle group
		logic        split;     // Access needs two bus transactions
		logic [4:0]  rd;
		logic        rd_wr;
		logic [4:0]  rs1;
		logic        rs1_rd;
		logic [4:0]  rs2;
		logic        rs2_rd;
		logic [31:0] divisor;
	} pct_instr_t;

	// Execute stage occupancy
	typedef struct packed {
		logic             valid;
		pct_cls_t         cls;
		logic [4:0]       rd;
		logic             rd_wr;
		logic             split;
		logic [CNT_W-1:0] cnt;
	} pct_ex_t;

	// Writeback stage occupancy
	typedef struct packed {
		logic       valid;
		logic [1:0] cnt;
	} pct_wb_t;

endpackage

// [src/pct_pipe_timing.sv]
// Operation
// - Four in-order stages, loads write back late
// - Counts assume memories insert no waits
// - Integer computation takes one cycle
// - Listed CSRs four cycles, others one
// - Aligned access: one cycle execute, writeback
// - Split access: two cycles each stage
// - Event load wait takes four cycles
// - Low-word multiply completes in one cycle
// - Upper-word multiplies take five cycles
// - Divide takes three to thirty-five cycles
// - Zero divisor takes thirty-five cycles
// - Jumps resolve in decode, flush fetch
// - Jump target request while jump decodes
// - Untaken branch takes one cycle
// - Taken branch flushes fetch and decode
// - Fetch fence jumps to next instruction
// - Load-use costs one stall cycle
// - Register jump after writer stalls once
`timescale 1ns/10ps
`default_nettype none
module pct_pipe_timing
	import pct_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        fetch_vld,
	input  wire pct_instr_t  fetch_instr,
	input  wire logic        br_taken,
	input  wire logic [31:0] br_target,
	input  wire logic        br_tgt_odd,
	output logic             fetch_take_q,
	output logic             fetch_req_q,
	output logic [31:0]      fetch_addr_q,
	output logic             flush_fetch_q,
	output logic             flush_decode_q,
	output logic             decode_busy_q,
	output logic             execute_busy_q,
	output logic             writeback_busy_q,
	output logic [1:0]       retire_q
);

	// Leading zero bits of the divisor, 32 for zero
	// A zero divisor counts every bit and so gives the longest divide
	function automatic logic [CNT_W-1:0] lead_zeros(input logic [31:0] v);
		logic [CNT_W-1:0] n;
		logic             seen;
		n = '0;
		seen = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i])
				seen = 1'b1;
			if (!seen)
				n = n + CYC_ONE;
		end
		return n;
	endfunction

	// Cycles an instruction spends in execute
	function automatic logic [CNT_W-1:0] ex_len(input pct_instr_t i);
		logic [CNT_W-1:0] n;
		n = CYC_ALU;
		unique case (i.cls)
			PCT_CSR:   n = i.csr_slow ? CYC_CSR_SLOW : CYC_CSR_FAST;
			PCT_LOAD,
			PCT_STORE: n = i.split ? CYC_MEM_SPLIT : CYC_MEM;
			PCT_ELW:   n = CYC_ELW - CYC_MEM;
			PCT_MUL:   n = CYC_MUL;
			PCT_MULH:  n = CYC_MULH;
			PCT_DIV:   n = CYC_DIV_MIN + lead_zeros(i.divisor);
			PCT_ALU, PCT_JUMP, PCT_JUMP_REG, PCT_BRANCH, PCT_FENCE:
				n = CYC_ALU;
			default:   n = CYC_ALU;
		endcase
		return n;
	endfunction

	function automatic logic is_mem(input pct_cls_t c);
		return (c == PCT_LOAD) || (c == PCT_STORE) || (c == PCT_ELW);
	endfunction

	function automatic logic is_jump(input pct_cls_t c);
		return (c == PCT_JUMP) || (c == PCT_JUMP_REG) || (c == PCT_FENCE);
	endfunction

	// Execute leaves this cycle; memory ops need writeback room
	// A blocked load keeps execute, so writeback completions stay in program order
	function automatic logic ex_leaves(input pct_ex_t e, input pct_wb_t w);
		logic wb_room;
		wb_room = !w.valid || (w.cnt == WB_ONE);
		return e.valid && (e.cnt == CYC_ONE) && (!is_mem(e.cls) || wb_room);
	endfunction

	// Decode cannot hand its instruction on this cycle
	// A hazard costs one cycle: the consumer moves once the producer has left execute
	function automatic logic dec_hold(input logic dv, input pct_instr_t d, input pct_ex_t e, input pct_wb_t w);
		logic ex_free;
		logic dep;
		logic ld_use;
		logic jr_use;
		ex_free = !e.valid || ex_leaves(e, w);
		dep = e.valid && e.rd_wr && (e.rd != REG_ZERO) &&
			((d.rs1_rd && (d.rs1 == e.rd)) || (d.rs2_rd && (d.rs2 == e.rd)));
		ld_use = dep && ((e.cls == PCT_LOAD) || (e.cls == PCT_ELW));
		jr_use = (d.cls == PCT_JUMP_REG) && e.valid && e.rd_wr &&
			(e.rd != REG_ZERO) && (d.rs1 == e.rd);
		return dv && (!ex_free || ld_use || jr_use);
	endfunction

	// Refused fetch cycles after a jump leaves decode; the cycle it sits in
	// decode and the offer dropped there already make up two of its count
	function automatic logic [CNT_W-1:0] jump_len(input pct_instr_t d);
		logic [CNT_W-1:0] n;
		if (d.cls == PCT_FENCE)
			n = d.tgt_odd ? CYC_FENCE_ODD : CYC_FENCE;
		else
			n = d.tgt_odd ? CYC_JUMP_ODD : CYC_JUMP;
		return n - CYC_ONE - CYC_ONE;
	endfunction

	logic             dec_vld_q;
	logic             dec_vld_d;
	pct_instr_t       dec_q;
	pct_instr_t       dec_d;
	pct_ex_t          ex_q;
	pct_ex_t          ex_d;
	pct_wb_t          wb_q;
	pct_wb_t          wb_d;
	logic [CNT_W-1:0] bubble_q;
	logic [CNT_W-1:0] bubble_d;
	logic             take_d;
	logic             req_d;
	logic [31:0]      addr_d;
	logic             flush_f_d;
	logic             flush_dec_d;
	logic [1:0]       retire_d;
	logic             dec_go;
	logic             ex_done;
	logic             br_flush;
	logic             jump_go;
	logic             wb_done;
	logic             jump_next;

	// Stage advance and flushes
	// A flushing branch drops whatever decode holds, so a jump there never goes
	always_comb begin
		dec_go = dec_vld_q && !dec_hold(dec_vld_q, dec_q, ex_q, wb_q);
		ex_done = ex_leaves(ex_q, wb_q);
		br_flush = ex_done && (ex_q.cls == PCT_BRANCH) && br_taken;
		jump_go = dec_go && is_jump(dec_q.cls) && !br_flush;
		wb_done = wb_q.valid && (wb_q.cnt == WB_ONE);
	end

	// Writeback holds loads one cycle, two when split
	// The event load is one word access and never splits
	always_comb begin
		wb_d = wb_q;
		if (wb_q.valid && !wb_done)
			wb_d.cnt = wb_q.cnt - WB_ONE;
		else if (wb_done)
			wb_d.valid = 1'b0;
		if (ex_done && is_mem(ex_q.cls)) begin
			wb_d.valid = 1'b1;
			wb_d.cnt = (ex_q.split && (ex_q.cls != PCT_ELW)) ? WB_SPLIT : WB_ONE;
		end
	end

	// Execute counts down its instruction's cycles
	// A slot flushed by a branch enters execute empty
	always_comb begin
		ex_d = ex_q;
		if (!ex_q.valid || ex_done) begin
			ex_d.valid = dec_go && !br_flush;
			ex_d.cls = dec_q.cls;
			ex_d.rd = dec_q.rd;
			ex_d.rd_wr = dec_q.rd_wr;
			ex_d.split = dec_q.split;
			ex_d.cnt = ex_len(dec_q);
		end else if (ex_q.cnt != CYC_ONE) begin
			ex_d.cnt = ex_q.cnt - CYC_ONE;
		end
	end

	// Decode takes a new instruction when free and not flushed
	always_comb begin
		dec_vld_d = dec_vld_q;
		dec_d = dec_q;
		if (br_flush || jump_go) begin
			dec_vld_d = 1'b0;
		end else if (!dec_vld_q || dec_go) begin
			dec_vld_d = fetch_vld && fetch_take_q;
			dec_d = fetch_instr;
		end
	end

	// Empty decode cycles after a control transfer
	// A branch flush outranks a jump that waits behind it
	always_comb begin
		if (br_flush)
			bubble_d = (br_tgt_odd ? CYC_BR_ODD : CYC_BR_TAKEN) - CYC_ONE;
		else if (jump_go)
			bubble_d = jump_len(dec_q);
		else if (bubble_q != '0)
			bubble_d = bubble_q - CYC_ONE;
		else
			bubble_d = '0;
	end

	// Jump target requested while the jump sits in decode
	// A fence asks for the next word; a branch flush wins over both
	always_comb begin
		jump_next = dec_vld_d && is_jump(dec_d.cls) && !dec_hold(dec_vld_d, dec_d, ex_d, wb_d);
		req_d = jump_next || br_flush;
		if (br_flush)
			addr_d = br_target;
		else if (dec_d.cls == PCT_FENCE)
			addr_d = dec_d.pc + FENCE_STEP;
		else
			addr_d = dec_d.target;
		flush_f_d = req_d;
		flush_dec_d = br_flush;

		// Decode accepts next cycle only if it will move on
		// Judging the next state keeps the registered take from over-accepting
		take_d = (bubble_d == '0) && !jump_next && !dec_hold(dec_vld_d, dec_d, ex_d, wb_d);
	end

	// Completions: non-memory from execute, loads from writeback
	always_comb begin
		retire_d = {1'b0, ex_done && !is_mem(ex_q.cls)} + {1'b0, wb_done};
	end

	// Decode registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dec_vld_q <= 1'b0;
			dec_q <= '0;
		end else begin
			dec_vld_q <= dec_vld_d;
			dec_q <= dec_d;
		end
	end

	// Execute register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ex_q <= '0;
		end else begin
			ex_q <= ex_d;
		end
	end

	// Writeback register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wb_q <= '0;
		end else begin
			wb_q <= wb_d;
		end
	end

	// Bubble counter
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bubble_q <= '0;
		end else begin
			bubble_q <= bubble_d;
		end
	end

	// Registered fetch-side outputs
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			fetch_take_q <= 1'b0;
			fetch_req_q <= 1'b0;
			fetch_addr_q <= '0;
			flush_fetch_q <= 1'b0;
			flush_decode_q <= 1'b0;
		end else begin
			fetch_take_q <= take_d;
			fetch_req_q <= req_d;
			fetch_addr_q <= addr_d;
			flush_fetch_q <= flush_f_d;
			flush_decode_q <= flush_dec_d;
		end
	end

	// Registered stage status
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			decode_busy_q <= 1'b0;
			execute_busy_q <= 1'b0;
			writeback_busy_q <= 1'b0;
			retire_q <= 2'h0;
		end else begin
			decode_busy_q <= dec_vld_d;
			execute_busy_q <= ex_d.valid;
			writeback_busy_q <= wb_d.valid;
			retire_q <= retire_d;
		end
	end

endmodule
`default_nettype wire

// [bench/pct_fetch_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pct_fetch_model
	import pct_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       want,
	input  wire pct_instr_t nxt,
	output wire logic       fetch_vld,
	output wire pct_instr_t fetch_instr
);
	pct_instr_t last = '0;
	// Zero-wait source; between offers the bus shows the inverse of its last word
	assign fetch_vld = want;
	assign fetch_instr = want ? nxt : pct_instr_t'(~last);
	// Remember the last word offered
	always @(posedge mclk) begin
		if (want) last <= nxt;
	end
endmodule
`default_nettype wire

// [bench/pct_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module pct_chk (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       fetch_vld,
	input wire logic       fetch_take_q,
	input wire logic       fetch_req_q,
	input wire logic       flush_fetch_q,
	input wire logic       flush_decode_q,
	input wire logic       decode_busy_q,
	input wire logic       execute_busy_q,
	input wire logic       writeback_busy_q,
	input wire logic [1:0] retire_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Offer taken with no branch flush behind it
	sequence s_take;
		fetch_vld && fetch_take_q ##1 !flush_decode_q;
	endsequence
	take_decode_a: assert property (s_take |-> decode_busy_q) else $error("take lost");
	jump_decode_a: assert property (fetch_req_q && !flush_decode_q |-> decode_busy_q) else $error("late req");
	jump_bubble_a: assert property (fetch_req_q && !flush_decode_q |=> !decode_busy_q) else $error("no bubble");
	req_flush_a: assert property (fetch_req_q |-> flush_fetch_q) else $error("no flush");
	branch_flush_a: assert property (flush_decode_q |-> fetch_req_q) else $error("bad flush");
	branch_empty_a: assert property (flush_decode_q |=> !decode_busy_q) else $error("decode kept");
	wb_source_a: assert property (writeback_busy_q |-> $past(execute_busy_q || writeback_busy_q)) else $error("bad wb");
	retire_src_a: assert property (retire_q != 2'h0 |-> retire_q != 2'h3 &&
		$past(execute_busy_q || writeback_busy_q)) else $error("bad retire");
endmodule
bind pct_pipe_timing pct_chk pct_chk_inst (.mclk, .rst_b, .fetch_vld, .fetch_take_q, .fetch_req_q, .flush_fetch_q,
	.flush_decode_q, .decode_busy_q, .execute_busy_q, .writeback_busy_q, .retire_q);
`default_nettype wire

// [bench/pct_pipe_timing_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pct_pipe_timing_tb_top
	import pct_pkg::*;
;
	logic        mclk, rst_b, want, br_taken, br_tgt_odd, fetch_vld, fetch_take_q, fetch_req_q;
	logic        flush_fetch_q, flush_decode_q, decode_busy_q, execute_busy_q, writeback_busy_q;
	logic [1:0]  retire_q;
	logic [31:0] br_target, fetch_addr_q, cyc, ex_n, wb_n, tl_n, rq_n, fd_n, addr, c0, rt_n;
	pct_instr_t  nxt, fetch_instr;
	int          bad_count, cmp_count, seed;

	pct_fetch_model pct_fetch_model_inst (.mclk, .want, .nxt, .fetch_vld, .fetch_instr);
	pct_pipe_timing pct_pipe_timing_inst (.mclk, .rst_b, .fetch_vld, .fetch_instr, .br_taken, .br_target,
		.br_tgt_odd, .fetch_take_q, .fetch_req_q, .fetch_addr_q, .flush_fetch_q, .flush_decode_q,
		.decode_busy_q, .execute_busy_q, .writeback_busy_q, .retire_q);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Expected execute cycles, three plus leading zeros for a divide
	function automatic logic [31:0] exp_ex(pct_instr_t i);
		logic [31:0] z;
		z = 3;
		for (int k = 31; k >= 0 && i.divisor[k] !== 1'b1; k--) z++;
		case (i.cls)
			PCT_CSR: return i.csr_slow ? 4 : 1;
			PCT_LOAD, PCT_STORE: return i.split ? 2 : 1;
			PCT_ELW: return 3;
			PCT_MULH: return 5;
			PCT_DIV: return z;
			default: return 1;
		endcase
	endfunction

	// Expected cycles with fetch refused after a control transfer
	function automatic logic [31:0] exp_tl(pct_instr_t i);
		case (i.cls)
			PCT_JUMP, PCT_JUMP_REG, PCT_FENCE: return i.tgt_odd ? 2 : 1;
			PCT_BRANCH: return br_taken ? (br_tgt_odd ? 3 : 2) : 0;
			default: return 0;
		endcase
	endfunction

	function automatic logic [31:0] exp_addr(pct_instr_t i);
		case (i.cls)
			PCT_JUMP, PCT_JUMP_REG: return i.target;
			PCT_FENCE: return i.pc + 32'h4;
			PCT_BRANCH: return br_taken ? br_target : 0;
			default: return 0;
		endcase
	endfunction

	function automatic pct_instr_t rnd(int c);
		pct_instr_t i;
		i = '0;
		i.cls = pct_cls_t'(c[3:0]);
		i.pc = $urandom;
		i.target = $urandom;
		{i.tgt_odd, i.csr_slow, i.split} = 3'($urandom);
		i.divisor = $urandom >> $urandom_range(32);
		return i;
	endfunction

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic hung();
		bad_count++;
		results();
	endtask

	// Sample settled outputs on the falling edge and count stage activity
	task automatic tick();
		@(negedge mclk);
		cyc += 1;
		ex_n += execute_busy_q;
		wb_n += writeback_busy_q;
		tl_n += !fetch_take_q;
		fd_n += flush_decode_q;
		rq_n += fetch_req_q;
		rt_n += retire_q;
		if (fetch_req_q === 1'b1) addr = fetch_addr_q;
	endtask

	// Offer one instruction; it is taken at the first rising edge with fetch_take_q high
	task automatic issue(pct_instr_t i);
		int n;
		n = 0;
		tick();
		want = 1'b1;
		nxt = i;
		while (fetch_take_q !== 1'b1) begin
			tick();
			n++;
			if (n > 60) hung();
		end
	endtask

	// Stop offering and wait for an empty pipe that accepts again
	task automatic drain();
		int n;
		n = 0;
		tick();
		want = 1'b0;
		while ({decode_busy_q, execute_busy_q, writeback_busy_q, fetch_take_q} !== 4'h1) begin
			tick();
			n++;
			if (n > 80) hung();
		end
	endtask

	task automatic one(pct_instr_t i);
		br_taken = 1'($urandom);
		br_tgt_odd = 1'($urandom);
		br_target = $urandom;
		{cyc, ex_n, wb_n, tl_n, rq_n, fd_n, addr, rt_n} = '0;
		issue(i);
		drain();
		chk(ex_n, exp_ex(i));
		chk(wb_n, i.cls == PCT_ELW ? 1 : i.cls inside {PCT_LOAD, PCT_STORE} ? 32'(i.split) + 1 : 0);
		chk(tl_n, exp_tl(i));
		chk(rq_n, 32'(exp_tl(i) != 0));
		chk(fd_n, 32'(i.cls == PCT_BRANCH && br_taken));
		chk(addr, exp_addr(i));
		chk(rt_n, 32'h1);
		$display("test of class %0d done", i.cls);
	endtask

	// Back-to-back pair, with and without a register dependence
	task automatic pair(pct_cls_t a, pct_cls_t b);
		pct_instr_t x, y;
		x = rnd(a);
		y = rnd(b);
		{x.rd, x.rd_wr, x.split, y.rs1_rd} = {5'h05, 3'h5};
		for (int h = 0; h < 2; h++) begin
			y.rs1 = h ? 5'h05 : 5'h06;
			{cyc, ex_n, wb_n, tl_n, rq_n, fd_n, addr, rt_n} = '0;
			issue(x);
			issue(y);
			drain();
			chk(rt_n, 32'h2);
			if (h) chk(cyc - c0, 32'h1);
			else c0 = cyc;
		end
		$display("hazard test done");
	endtask

	initial begin
		pct_instr_t t;
		{rst_b, want, br_taken, br_tgt_odd, br_target, nxt} = '0;
		seed = $urandom(86);
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		for (int c = 0; c < 12; c++) begin
			repeat (4) one(rnd(c));
		end
		t = rnd(7);
		t.divisor = 32'h0;
		one(t);
		t.divisor = 32'h8000_0000;
		one(t);
		pair(PCT_LOAD, PCT_ALU);
		pair(PCT_ALU, PCT_JUMP_REG);
		results();
	end
endmodule
`default_nettype wire
